// file: verilog/rco_ref_clock.sv
// Reference clock output generator with its control registers.
`timescale 1ns/10ps
`include "rco_defs.svh"

// Behaviour
// - Generated clock drives the output pin and the on-chip reference.
// - Generator input comes from the source chosen by the source field.
// - Enabling starts output on a source rising edge with no runt pulse.
// - Clearing the enable stops the output immediately.
// - Divide the source by 1, 2, 4 up to 128 via divider field.
// - High time is 0, 25, 50 or 75 percent; ignored when undivided.
// - Duty field resets to 50 percent, upper bit set.
// - Runs on system clock; outputs hold their level during sleep.
// - Sleep changes no configuration or state; operation resumes.
// - Duty codes: 11 is 75, 10 is 50, 01 is 25, 00 is 0.
// - Divider value n divides by two to the power n.
// - Source codes 0 to 10 select eleven clocks; others reserved.
// - Enable bit one turns the generator on; resets to zero.
module rco_ref_clock
  import rco_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        sleep_mode,
  input  wire logic [10:1] source_levels,
  input  wire logic [3:0]  address,
  input  wire logic [7:0]  write_data,
  input  wire logic        write_strobe,
  input  wire logic        read_strobe,
  output logic      [7:0]  read_data,
  output logic             ref_clock_out,
  output logic             ref_clock_internal
);

  // Configuration registers.
  rco_control_s ref_control_reg;
  logic [3:0]   source_select_reg;
  rco_control_s next_ref_control_reg;
  logic [3:0]   next_source_select_reg;
  logic [7:0]   next_read_data;

  // Generator state.
  rco_state_e   state;
  rco_state_e   next_state;
  logic [7:0]   phase;
  logic [7:0]   next_phase;
  logic [3:0]   active_select;
  logic [3:0]   next_active_select;
  logic         out_level;
  logic         next_out_level;
  logic         system_toggle;
  logic         next_system_toggle;

  // Selected source view.
  logic [10:0]  all_levels;
  logic         src_level;
  logic         src_rise;
  logic         src_fall;
  logic [7:0]   period_mask;
  logic [7:0]   stepped_phase;

  // High length in half source periods for a divider and duty code.
  function automatic logic [7:0] high_length(input logic [2:0] div,
                                             input rco_duty_e duty);
    logic [8:0] half_periods;
    half_periods = 9'h002 << div;
    case (duty)
      RCO_DUTY_25: high_length = {1'b0, half_periods[8:2]};
      RCO_DUTY_50: high_length = half_periods[8:1];
      RCO_DUTY_75: high_length = {1'b0, half_periods[8:2]} * 8'h03;
      default:     high_length = 8'h00;
    endcase
  endfunction

  // The system clock source is a level toggling on every rising clock edge outside sleep.
  assign all_levels = {source_levels, system_toggle};

  rco_source_tap #(
    .SOURCES (`RCO_SOURCE_COUNT)
  ) u_tap (
    .clock   (clock),
    .reset_n (reset_n),
    .freeze  (sleep_mode),
    .levels  (all_levels),
    .select  (active_select),
    .level   (src_level),
    .rise    (src_rise),
    .fall    (src_fall)
  );

  // Register writes and registered reads.
  always_comb begin
    next_ref_control_reg = ref_control_reg;
    next_source_select_reg = source_select_reg;
    next_read_data = 8'h00;
    if (write_strobe) begin
      if (address == `RCO_CONTROL_OFFSET) begin
        next_ref_control_reg.on = write_data[`RCO_ON_BIT];
        next_ref_control_reg.duty_select =
          rco_duty_e'(write_data[`RCO_DUTY_MSB:`RCO_DUTY_LSB]);
        next_ref_control_reg.divider =
          write_data[`RCO_DIV_MSB:`RCO_DIV_LSB];
      end else if (address == `RCO_SOURCE_OFFSET) begin
        next_source_select_reg = write_data[`RCO_SRC_MSB:`RCO_SRC_LSB];
      end
    end
    if (read_strobe) begin
      if (address == `RCO_CONTROL_OFFSET) begin
        next_read_data[`RCO_ON_BIT] = ref_control_reg.on;
        next_read_data[`RCO_DUTY_MSB:`RCO_DUTY_LSB] =
          ref_control_reg.duty_select;
        next_read_data[`RCO_DIV_MSB:`RCO_DIV_LSB] = ref_control_reg.divider;
      end else if (address == `RCO_SOURCE_OFFSET) begin
        next_read_data[`RCO_SRC_MSB:`RCO_SRC_LSB] = source_select_reg;
      end else if (address == `RCO_STATUS_OFFSET) begin
        next_read_data[`RCO_STAT_RUN_BIT] = (state == RCO_RUN);
        next_read_data[`RCO_STAT_OUT_BIT] = out_level;
        next_read_data[7:`RCO_STAT_SEL_LSB] = active_select;
      end
    end
  end

  // Configuration flops; reset gives 50 percent duty and the generator off.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ref_control_reg.on <= `RCO_ON_RESET;
      ref_control_reg.duty_select <= rco_duty_e'(`RCO_DUTY_RESET);
      ref_control_reg.divider <= `RCO_DIV_RESET;
      source_select_reg <= `RCO_SRC_RESET;
      read_data <= 8'h00;
    end else begin
      ref_control_reg <= next_ref_control_reg;
      source_select_reg <= next_source_select_reg;
      read_data <= next_read_data;
    end
  end

  // Phase counts both edges of the source, so one output period spans
  // two to the divider plus one source edges.
  assign period_mask =
    8'((9'h002 << ref_control_reg.divider) - 9'h001);
  assign stepped_phase = (phase + 8'h01) & period_mask;

  // Generator sequencing; sleep freezes every piece of state.
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_active_select = active_select;
    next_out_level = out_level;
    next_system_toggle = ~system_toggle;
    if (sleep_mode) begin
      next_system_toggle = system_toggle;
    end else if (!ref_control_reg.on) begin
      next_state = RCO_IDLE;
      next_phase = 8'h00;
      next_out_level = 1'b0;
      next_active_select = source_select_reg;
    end else begin
      case (state)
        RCO_IDLE: begin
          next_state = RCO_ARMED;
          next_active_select = source_select_reg;
        end
        RCO_ARMED: begin
          next_active_select = source_select_reg;
          if (src_rise && active_select == source_select_reg) begin
            next_state = RCO_RUN;
            next_phase = 8'h00;
            next_out_level = (ref_control_reg.divider == 3'h0) ||
              (high_length(ref_control_reg.divider,
                           ref_control_reg.duty_select) != 8'h00);
          end
        end
        RCO_RUN: begin
          if (src_rise || src_fall) begin
            next_phase = stepped_phase;
            if (ref_control_reg.divider == 3'h0) begin
              next_out_level = src_level;
            end else begin
              next_out_level = stepped_phase < high_length(
                ref_control_reg.divider,
                ref_control_reg.duty_select);
            end
            if (stepped_phase == 8'h00 &&
                active_select != source_select_reg) begin
              next_state = RCO_ARMED;
              next_out_level = 1'b0;
            end
          end
        end
        default: begin
          next_state = RCO_IDLE;
        end
      endcase
    end
  end

  // Generator flops, clocked from the system clock.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= RCO_IDLE;
      phase <= 8'h00;
      active_select <= `RCO_SRC_RESET;
      out_level <= 1'b0;
      system_toggle <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      active_select <= next_active_select;
      out_level <= next_out_level;
      system_toggle <= next_system_toggle;
    end
  end

  // One flop feeds both the pin and the on-chip reference.
  assign ref_clock_out = out_level;
  assign ref_clock_internal = out_level;

endmodule

// file: verilog/rco_defs.svh
// Offsets, field positions, reset values and counts of the reference clock.
`ifndef RCO_DEFS_SVH
`define RCO_DEFS_SVH

// Register indices on the plain register port.
`define RCO_CONTROL_OFFSET   4'h0
`define RCO_SOURCE_OFFSET    4'h1
`define RCO_STATUS_OFFSET    4'h2

// Control register field positions.
`define RCO_ON_BIT           7
`define RCO_DUTY_MSB         4
`define RCO_DUTY_LSB         3
`define RCO_DIV_MSB          2
`define RCO_DIV_LSB          0

// Source register field positions.
`define RCO_SRC_MSB          3
`define RCO_SRC_LSB          0

// Status register field positions.
`define RCO_STAT_RUN_BIT     0
`define RCO_STAT_OUT_BIT     1
`define RCO_STAT_SEL_LSB     4

// Reset values.
`define RCO_ON_RESET         1'h0
`define RCO_DUTY_RESET       2'h2
`define RCO_DIV_RESET        3'h0
`define RCO_SRC_RESET        4'h0

// Number of selectable sources, codes 0 to 10.
`define RCO_SOURCE_COUNT     11

`endif

// file: verilog/rco_pkg.sv
// Types shared by the reference clock output files.
package rco_pkg;

  // Source select codes; codes above 10 are reserved.
  typedef enum logic [3:0] {
    RCO_SRC_SYSTEM   = 4'h0,
    RCO_SRC_HIGH_OSC = 4'h1,
    RCO_SRC_LOW_OSC  = 4'h2,
    RCO_SRC_MID_500K = 4'h3,
    RCO_SRC_MID_31K  = 4'h4,
    RCO_SRC_SEC_OSC  = 4'h5,
    RCO_SRC_NUM_OSC  = 4'h6,
    RCO_SRC_CELL_1   = 4'h7,
    RCO_SRC_CELL_2   = 4'h8,
    RCO_SRC_CELL_3   = 4'h9,
    RCO_SRC_CELL_4   = 4'hA
  } rco_source_e;

  // Duty cycle codes.
  typedef enum logic [1:0] {
    RCO_DUTY_0  = 2'h0,
    RCO_DUTY_25 = 2'h1,
    RCO_DUTY_50 = 2'h2,
    RCO_DUTY_75 = 2'h3
  } rco_duty_e;

  // Generator states.
  typedef enum logic [1:0] {
    RCO_IDLE  = 2'b00,
    RCO_ARMED = 2'b01,
    RCO_RUN   = 2'b10
  } rco_state_e;

  // Contents of the control register.
  typedef struct packed {
    logic      on;
    rco_duty_e duty_select;
    logic [2:0] divider;
  } rco_control_s;

endpackage

// file: verilog/rco_source_tap.sv
// Source multiplexer with edge detection on the selected source level.
`timescale 1ns/10ps

module rco_source_tap
  import rco_pkg::*;
#(
  parameter int SOURCES = 11
) (
  input  wire logic               clock,
  input  wire logic               reset_n,
  input  wire logic               freeze,
  input  wire logic [SOURCES-1:0] levels,
  input  wire logic [3:0]         select,
  output logic                    level,
  output logic                    rise,
  output logic                    fall
);

  logic prev;
  logic next_prev;

  // Pick the selected source; reserved codes give a quiet low level.
  always_comb begin
    level = 1'b0;
    if (select < 4'(SOURCES)) begin
      level = levels[select];
    end
    rise = level & ~prev;
    fall = ~level & prev;
    next_prev = freeze ? prev : level;
  end

  // Previous level of the selected source.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end

endmodule

// file: test/rco_source_farm.sv
// Far-side model: ten free-running source clocks of distinct rates.
`timescale 1ns/10ps
module rco_source_farm (
  input  wire logic        clock,
  input  wire logic        reset_n,
  output logic      [10:1] source_levels
);
  int cnt [10:1];
  // Source n toggles every n cycles, so its edges are n cycles apart.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      source_levels <= 10'h000;
      for (int n = 1; n <= 10; n++) cnt[n] <= 0;
    end else begin
      for (int n = 1; n <= 10; n++) begin
        if (cnt[n] == n - 1) begin
          cnt[n] <= 0;
          source_levels[n] <= ~source_levels[n];
        end else begin
          cnt[n] <= cnt[n] + 1;
        end
      end
    end
  end
endmodule

// file: test/rco_ref_clock_chk.sv
// Port checker for the reference clock output generator.
`timescale 1ns/10ps
module rco_ref_clock_chk
  import rco_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        sleep_mode,
  input wire logic [3:0]  address,
  input wire logic [7:0]  write_data,
  input wire logic        write_strobe,
  input wire logic        read_strobe,
  input wire logic [7:0]  read_data,
  input wire logic        ref_clock_out,
  input wire logic        ref_clock_internal
);
  logic [7:0] ctl;
  logic [3:0] src;
  logic [7:0] next_ctl;
  logic [3:0] next_src;
  // Shadows of the writable registers, built from observed writes.
  always_comb begin
    next_ctl = ctl;
    next_src = src;
    if (write_strobe && address == 4'h0) next_ctl = write_data & 8'h9F;
    if (write_strobe && address == 4'h1) next_src = write_data[3:0];
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctl <= 8'h10;
      src <= 4'h0;
    end else begin
      ctl <= next_ctl;
      src <= next_src;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_same_pin; ref_clock_internal == ref_clock_out; endproperty
  a_same_pin: assert property (p_same_pin)
    else $error("pin and internal copy differ");
  property p_rd_idle; !read_strobe |=> read_data == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_rd_ctl;
    read_strobe && address == 4'h0 |=> read_data == $past(ctl);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl)
    else $error("control read back wrong");
  property p_rd_src;
    read_strobe && address == 4'h1 |=> read_data == {4'h0, $past(src)};
  endproperty
  a_rd_src: assert property (p_rd_src)
    else $error("source read back wrong");
  property p_unmapped;
    read_strobe && address > 4'h2 |=> read_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_off_low; !ctl[7] && !sleep_mode |=> !ref_clock_out; endproperty
  a_off_low: assert property (p_off_low)
    else $error("output high while off");
  property p_start_clean; $rose(ctl[7]) |-> !ref_clock_out [*2]; endproperty
  a_start_clean: assert property (p_start_clean)
    else $error("output rose before arming");
  property p_sleep_hold; sleep_mode |=> $stable(ref_clock_out); endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("output moved in sleep");
  property p_duty_zero;
    ctl[7] && ctl[4:3] == 2'h0 && ctl[2:0] != 3'h0 && !sleep_mode
      |=> !ref_clock_out;
  endproperty
  a_duty_zero: assert property (p_duty_zero)
    else $error("zero duty output high");
  c_run: cover property ($rose(ref_clock_out));
  c_nap: cover property (sleep_mode ##1 !sleep_mode);
  c_stop: cover property ($fell(ctl[7]) ##1 !ref_clock_out);
endmodule

bind rco_ref_clock rco_ref_clock_chk u_chk (
  .clock(clock), .reset_n(reset_n), .sleep_mode(sleep_mode),
  .address(address), .write_data(write_data),
  .write_strobe(write_strobe), .read_strobe(read_strobe),
  .read_data(read_data), .ref_clock_out(ref_clock_out),
  .ref_clock_internal(ref_clock_internal)
);

// file: test/testbench.sv
// Self-checking bench for the reference clock output generator.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module testbench
  import rco_pkg::*;
;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        sleep_mode = 1'b0;
  logic [3:0]  address = 4'h0;
  logic [7:0]  write_data = 8'h00;
  logic        write_strobe = 1'b0;
  logic        read_strobe = 1'b0;
  logic [7:0]  read_data;
  logic [10:1] source_levels;
  logic        ref_clock_out;
  logic        ref_clock_internal;
  logic [7:0]  rq[$];
  logic [7:0]  want;
  logic [3:0]  a;
  logic        rd_pend = 1'b0;
  logic        prv = 1'b0;
  logic        armed = 1'b0;
  int          error_cnt = 0;
  int          checked = 0;
  int          run = 1;
  int          exp_hi = 0;
  int          exp_lo = 0;
  int          seed = 32'h15047F2F;
  int          v;

  rco_ref_clock dut (.clock(clock), .reset_n(reset_n),
    .sleep_mode(sleep_mode), .source_levels(source_levels),
    .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .ref_clock_out(ref_clock_out),
    .ref_clock_internal(ref_clock_internal));
  rco_source_farm u_src (.clock(clock), .reset_n(reset_n),
    .source_levels(source_levels));

  // Clock of 4 ns period.
  always #2 clock = ~clock;

  task automatic conclude;
    $display("errors %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    address <= ad;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
    @(posedge clock);
  endtask

  // Issues a read and notes the value the monitor must see next cycle.
  task automatic rd(input logic [3:0] ad, input logic [7:0] d);
    address <= ad;
    read_strobe <= 1'b1;
    rq.push_back(d);
    @(posedge clock);
    read_strobe <= 1'b0;
    @(posedge clock);
  endtask

  // Runs one source, divider and duty setting and notes pulse widths.
  task automatic cfg(input logic [3:0] s, input int r, input logic [2:0] dv,
                     input logic [1:0] dc, input logic nap);
    int p;
    int h;
    p = ((dv == 3'h0) ? 2 : (2 << dv)) * r;
    h = (dv == 3'h0) ? r : p * dc / 4;
    wr(4'h1, {4'h0, s});
    wr(4'h0, {3'h0, dc, dv});
    exp_hi <= h;
    exp_lo <= p - h;
    wr(4'h0, {3'h4, dc, dv});
    repeat (3 * p + 12) @(posedge clock);
    if (nap) begin
      sleep_mode <= 1'b1;
      repeat (20) @(posedge clock);
      sleep_mode <= 1'b0;
      rd(4'h0, {3'h4, dc, dv});
      repeat (3 * p) @(posedge clock);
    end
    exp_hi <= 0;
    wr(4'h0, 8'h00);
  endtask

  // Compares each read result with the oldest note.
  always @(posedge clock) begin
    if (rd_pend) begin
      want = rq.pop_front();
      `CHK(read_data, want)
    end
    rd_pend <= read_strobe;
  end

  // Measures high and low runs; the first, partial run is skipped.
  always @(posedge clock) begin
    if (exp_hi == 0 || sleep_mode || !reset_n) begin
      armed <= 1'b0;
      run <= 1;
    end else if (ref_clock_out !== prv) begin
      if (armed) `CHK(run, prv ? exp_hi : exp_lo)
      armed <= 1'b1;
      run <= 1;
    end else begin
      run <= run + 1;
    end
    prv <= ref_clock_out;
  end

  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(4'h0, 8'h10);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h00);
    wr(4'h0, 8'h7F);
    rd(4'h0, 8'h1F);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      a = (v[3:0] < 4'h3) ? 4'h3 : v[3:0];
      wr(a, v[15:8]);
      rd(a, 8'h00);
      wr(4'h1, v[23:16]);
      rd(4'h1, {4'h0, v[19:16]});
    end
    wr(4'h0, 8'h00);
    for (int d = 0; d < 8; d++) begin
      for (int c = 0; c < 4; c++) begin
        cfg(4'h0, 1, 3'(d), 2'(c), 1'b0);
      end
    end
    for (int s = 1; s <= 10; s++) begin
      cfg(4'(s), s, 3'h1, 2'h2, 1'b0);
    end
    cfg(4'h0, 1, 3'h3, 2'h3, 1'b1);
    // Switch from source 0 to source 1 while running; both give 2/2 runs.
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h91);
    repeat (10) @(posedge clock);
    wr(4'h1, 8'h01);
    repeat (12) @(posedge clock);
    exp_hi <= 2;
    exp_lo <= 2;
    repeat (24) @(posedge clock);
    exp_hi <= 0;
    // Reset in mid-run must clear the output and the configuration.
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    `CHK(ref_clock_out, 1'b0)
    rd(4'h0, 8'h10);
    wr(4'h1, 8'h0B);
    wr(4'h0, 8'h90);
    repeat (40) @(posedge clock);
    `CHK(ref_clock_out, 1'b0)
    // A reserved source leaves the generator armed and idle low.
    rd(4'h2, 8'hB0);
    wr(4'h0, 8'h00);
    conclude();
  end
endmodule
